//--- hdl/sfrdw_cfg.svh
// constants for the sfr decode and fifo window block
// assumes an 8-bit direct space and a 1 KB external data ram
`ifndef SFRDW_CFG_SVH
`define SFRDW_CFG_SVH

// direct space split: top bit set selects the register bank
`define SFRDW_SFR_SEL_BIT 7
// bit-addressable registers have low three address bits clear
`define SFRDW_BITABLE_LOW 3'h0
// bit address below 0x80 lands in ram bytes starting here
`define SFRDW_BIT_RAM_BASE 8'h20
// external memory configuration register
`define SFRDW_EMCFG_ADDR 8'h85
`define SFRDW_EMCFG_RESET 8'h03
`define SFRDW_FIFO_EN_BIT 6
`define SFRDW_EMCFG_FIXED_LO 6'h03
// fifo window 0x0400..0x07FF: address bits 15:10 equal to 1
`define SFRDW_WIN_PAGE 6'h01
`define SFRDW_EXTERNAL_DATA_RAM_AW 10
// occupancy of 0x80..0xFF, bit n stands for address 0x80+n
`define SFRDW_OCC_MAP 128'hFFFF_FFFF_7FFF_BFFF_7FFF_D7FF_FFFF_FFFF

`endif

//--- hdl/sfrdw_occ_rom.sv
// occupancy table of the special-function register space
// assumes the caller aligns its own outputs to the registered answer
`include "sfrdw_cfg.svh"

module sfrdw_occ_rom (
  input wire logic clock,       // core clock
  input wire logic sys_rst,     // async reset, active high
  input wire logic lookup,      // register-bank access this cycle
  input wire logic [6:0] index, // address minus 0x80
  output logic reserved_r       // registered: access hit a free slot
);

  // constant table; unoccupied entries are reserved
  localparam logic [127:0] OCC_MAP = `SFRDW_OCC_MAP;

  // registered lookup keeps the answer glitch free
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reserved_r <= 1'b0;
    end else begin
      reserved_r <= lookup && !OCC_MAP[index];
    end
  end

endmodule

//--- hdl/sfrdw_pkg.sv
// types shared by the sfr decode and fifo window block
// assumes sfrdw_cfg.svh is found on the include path
package sfrdw_pkg;

  // direct-addressing access from the core
  typedef struct packed {
    logic valid;       // access strobe, one cycle
    logic bit_op;      // bit access instead of byte
    logic we;          // write
    logic [7:0] addr;  // byte address, or bit address when bit_op
    logic [7:0] wdata; // byte data, bit value in wdata[0]
  } sfrdw_dir_req_t;

  // routed direct access
  typedef struct packed {
    logic sfr_sel;         // goes to the register bank
    logic ram_sel;         // goes to internal data ram
    logic bit_op;          // single bit access
    logic we;              // write
    logic [7:0] byte_addr; // byte address of the target
    logic [2:0] bit_pos;   // bit within the byte
    logic [7:0] wdata;     // write data
  } sfrdw_dir_route_t;

  // external-move access from the core
  typedef struct packed {
    logic valid;        // access strobe, one cycle
    logic we;           // write
    logic [15:0] addr;  // 16-bit external data address
    logic [7:0] wdata;  // write data
  } sfrdw_xm_req_t;

  // access toward fifo ram or external data ram
  typedef struct packed {
    logic fifo_req;     // fifo ram access, held until ack
    logic external_data_ram_req;     // external data ram access, one cycle
    logic we;           // write
    logic [9:0] addr;   // offset in the 1 KB target
    logic [7:0] wdata;  // write data
  } sfrdw_mem_req_t;

  typedef enum logic [0:0] {
    SFRDW_XM_IDLE = 1'b0,
    SFRDW_XM_FIFO = 1'b1
  } sfrdw_xm_state_t;

endpackage

//--- hdl/sfrdw_top.sv
// direct-space decode, external memory config and fifo window
// assumes one core clock and a fifo ram that acknowledges by a
// level synchronous to this clock
`include "sfrdw_cfg.svh"

module sfrdw_top (
  input wire logic clock,                        // core clock, 100 MHz
  input wire logic sys_rst,                      // async reset, high
  input wire sfrdw_pkg::sfrdw_dir_req_t dir_req, // direct access in
  input wire sfrdw_pkg::sfrdw_xm_req_t xm_req,   // external move in
  input wire logic fifo_ack,                     // fifo access finished
  output sfrdw_pkg::sfrdw_dir_route_t dir_out_r, // routed direct access
  output logic sfr_reserved_r,                   // hit unoccupied location
  output logic bit_refused_r,                    // bit op not allowed
  output logic [7:0] cfg_rdata_r,                // config read data
  output logic cfg_rvalid_r,                     // config read, pulse
  output logic fifo_window_enable_r,             // window state
  output sfrdw_pkg::sfrdw_mem_req_t mem_out_r,   // fifo or ram access
  output logic xm_wait_r,                        // core must stall
  output logic xm_done_r                         // move finished, pulse
);

  // byte and bit position of the direct access
  logic [7:0] dir_byte; // decoded byte address
  logic [2:0] dir_pos;  // decoded bit position
  logic dir_is_sfr;     // upper half of direct space
  logic dir_bit_ok;     // bit access permitted at this byte
  logic cfg_hit;        // byte access to the config register
  logic [6:0] occ_index; // table index for the occupancy rom
  logic sfr_access;     // register-bank access this cycle
  // reset image of the config register; only the enable is stored
  localparam logic [7:0] EMCFG_RESET = `SFRDW_EMCFG_RESET;

  // bit addresses 0x80..0xFF name bit-addressable registers,
  // lower ones name the 16 bit-addressable ram bytes
  always_comb begin
    dir_pos = 3'h0;
    dir_byte = dir_req.addr;
    if (dir_req.bit_op) begin
      dir_pos = dir_req.addr[2:0];
      if (dir_req.addr[`SFRDW_SFR_SEL_BIT]) begin
        dir_byte = {dir_req.addr[7:3], `SFRDW_BITABLE_LOW};
      end else begin
        dir_byte = `SFRDW_BIT_RAM_BASE + {4'h0, dir_req.addr[6:3]};
      end
    end
  end

  assign dir_is_sfr = dir_byte[`SFRDW_SFR_SEL_BIT];
  // a bit op on a byte-only register can only come from a bad
  // address; bit decode above never forms one, kept as a guard
  assign dir_bit_ok = (dir_byte[2:0] == `SFRDW_BITABLE_LOW);
  assign cfg_hit = dir_req.valid && !dir_req.bit_op &&
                   (dir_byte == `SFRDW_EMCFG_ADDR);
  assign occ_index = dir_byte[6:0];
  assign sfr_access = dir_req.valid && dir_is_sfr;

  // occupancy lookup answers in step with the routed access; the
  // reserved flag is advisory: the access still goes to the bank,
  // whose answer at such an address is undefined
  sfrdw_occ_rom u_occ (
    .clock(clock),
    .sys_rst(sys_rst),
    .lookup(sfr_access),
    .index(occ_index),
    .reserved_r(sfr_reserved_r)
  );

  // direct access routing, registered one cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dir_out_r <= '0;
    end else begin
      dir_out_r.sfr_sel <= sfr_access;
      dir_out_r.ram_sel <= dir_req.valid && !dir_is_sfr;
      dir_out_r.bit_op <= dir_req.bit_op;
      dir_out_r.we <= dir_req.we;
      dir_out_r.byte_addr <= dir_byte;
      dir_out_r.bit_pos <= dir_pos;
      dir_out_r.wdata <= dir_req.wdata;
    end
  end

  // refusal flag for a bit op on a byte-only register; kept apart
  // from the routing so a later refusal policy stays local
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bit_refused_r <= 1'b0;
    end else begin
      bit_refused_r <= sfr_access && dir_req.bit_op &&
                       !dir_bit_ok;
    end
  end

  // config register: only the window enable is stored
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fifo_window_enable_r <= EMCFG_RESET[`SFRDW_FIFO_EN_BIT];
    end else if (cfg_hit && dir_req.we) begin
      fifo_window_enable_r <= dir_req.wdata[`SFRDW_FIFO_EN_BIT];
    end
  end

  // read strobe for a byte read of the config register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rvalid_r <= 1'b0;
    end else begin
      cfg_rvalid_r <= cfg_hit && !dir_req.we;
    end
  end

  // config read: bit 7 zero, bits 5:0 fixed, writes there dropped;
  // refreshed every cycle, so it shows the enable one cycle late
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rdata_r <= 8'h00;
    end else begin
      cfg_rdata_r <= {1'b0, fifo_window_enable_r,
                      `SFRDW_EMCFG_FIXED_LO};
    end
  end

  // external-move decode
  sfrdw_pkg::sfrdw_xm_state_t xm_state_r; // move sequencer state
  logic in_window;  // address falls in 0x0400..0x07FF
  logic to_fifo;    // this move goes to the fifo ram
  logic xm_take;    // move accepted by the idle sequencer
  logic xm_ack;     // pending fifo move answered this cycle

  assign in_window = (xm_req.addr[15:10] == `SFRDW_WIN_PAGE);
  // the window only opens while the enable is set
  assign to_fifo = fifo_window_enable_r && in_window;
  // moves that arrive while a fifo move is pending are ignored; the
  // core is expected to honour the stall and not issue them
  assign xm_take = xm_req.valid &&
                   (xm_state_r == sfrdw_pkg::SFRDW_XM_IDLE);
  assign xm_ack = fifo_ack &&
                  (xm_state_r == sfrdw_pkg::SFRDW_XM_FIFO);

  // sequencer: ram moves take one cycle, fifo moves hold the core
  // until the fifo side acknowledges
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      xm_state_r <= sfrdw_pkg::SFRDW_XM_IDLE;
    end else begin
      case (xm_state_r)
        sfrdw_pkg::SFRDW_XM_IDLE: begin
          if (xm_take && to_fifo) begin
            xm_state_r <= sfrdw_pkg::SFRDW_XM_FIFO;
          end
        end
        sfrdw_pkg::SFRDW_XM_FIFO: begin
          // relies on the usb side running at least twice as fast
          if (fifo_ack) begin
            xm_state_r <= sfrdw_pkg::SFRDW_XM_IDLE;
          end
        end
        default: begin
          // unused code: fall back to idle
          xm_state_r <= sfrdw_pkg::SFRDW_XM_IDLE;
        end
      endcase
    end
  end

  // memory request: strobes follow the sequencer, the other fields
  // are loaded only when a move is taken and hold otherwise
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mem_out_r <= '0;
    end else begin
      // ram strobe lasts one cycle; with the window open the ram
      // under the window is never strobed
      mem_out_r.external_data_ram_req <= xm_take && !to_fifo;
      if (xm_take) begin
        mem_out_r.we <= xm_req.we;
        mem_out_r.wdata <= xm_req.wdata;
        // upper bits dropped: ram repeats over the 64 k space
        mem_out_r.addr <= xm_req.addr[`SFRDW_EXTERNAL_DATA_RAM_AW-1:0];
      end
      // fifo strobe stands until the fifo side answers
      if (xm_take && to_fifo) begin
        mem_out_r.fifo_req <= 1'b1;
      end else if (xm_ack) begin
        mem_out_r.fifo_req <= 1'b0;
      end
    end
  end

  // core stall: raised with a fifo move, dropped by the answer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      xm_wait_r <= 1'b0;
    end else if (xm_take && to_fifo) begin
      xm_wait_r <= 1'b1;
    end else if (xm_ack) begin
      xm_wait_r <= 1'b0;
    end
  end

  // completion pulse: with the ram strobe, or the cycle after the
  // fifo answer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      xm_done_r <= 1'b0;
    end else begin
      xm_done_r <= (xm_take && !to_fifo) || xm_ack;
    end
  end

endmodule

//--- verification/sfr_decode_fifo_window_test.sv
// self-checking bench for the register decode and fifo window
// assumes package, design, model and checker compiled first
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin \
  miscompares++; $display("FAIL %s exp %h got %h", n, e, a); end end
module sfr_decode_fifo_window_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, sys_rst = 1'b1, fifo_ack;
  logic [3:0] ack_delay = 4'h0;
  sfrdw_pkg::sfrdw_dir_req_t dir_req = '0;
  sfrdw_pkg::sfrdw_xm_req_t xm_req = '0;
  sfrdw_pkg::sfrdw_dir_route_t dir_out_r;
  sfrdw_pkg::sfrdw_mem_req_t mem_out_r;
  logic sfr_reserved_r, bit_refused_r, cfg_rvalid_r, fifo_window_enable_r;
  logic xm_wait_r, xm_done_r;
  logic [7:0] cfg_rdata_r;
  int checked = 0, miscompares = 0;
  // bit op, addr, sfr/ram/reserved, byte, bit position
  logic [22:0] rows [8] = '{
    {1'b0, 8'h85, 3'b100, 8'h85, 3'h0}, {1'b0, 8'h30, 3'b010, 8'h30, 3'h0},
    {1'b0, 8'hAB, 3'b101, 8'hAB, 3'h0}, {1'b0, 8'hDF, 3'b101, 8'hDF, 3'h0},
    {1'b0, 8'h87, 3'b100, 8'h87, 3'h0}, {1'b1, 8'h83, 3'b100, 8'h80, 3'h3},
    {1'b1, 8'hFF, 3'b100, 8'hF8, 3'h7}, {1'b1, 8'h13, 3'b010, 8'h22, 3'h3}};
  always #5 clock = ~clock;
  sfrdw_top i_dut (.clock(clock), .sys_rst(sys_rst), .dir_req(dir_req),
    .xm_req(xm_req), .fifo_ack(fifo_ack), .dir_out_r(dir_out_r),
    .sfr_reserved_r(sfr_reserved_r), .bit_refused_r(bit_refused_r),
    .cfg_rdata_r(cfg_rdata_r), .cfg_rvalid_r(cfg_rvalid_r),
    .fifo_window_enable_r(fifo_window_enable_r), .mem_out_r(mem_out_r),
    .xm_wait_r(xm_wait_r), .xm_done_r(xm_done_r));
  sfrdw_fifo_model i_fifo (.clock(clock), .sys_rst(sys_rst),
    .fifo_req(mem_out_r.fifo_req), .ack_delay(ack_delay),
    .fifo_ack(fifo_ack));
  // one direct access; outputs settled on return
  task automatic dir(input logic b, w, input logic [7:0] a, d);
    @(posedge clock) dir_req <= '{1'b1, b, w, a, d};
    @(posedge clock) dir_req.valid <= 1'b0;
    #1;
  endtask
  // byte write of the config register, then read back
  task automatic cfg(input logic [7:0] d, x);
    dir(1'b0, 1'b1, 8'h85, d);
    `CHK("dir_we", 1'b1, dir_out_r.we)
    `CHK("dir_wdata", d, dir_out_r.wdata)
    dir(1'b0, 1'b0, 8'h85, 8'h00);
    `CHK("cfg_rvalid", 1'b1, cfg_rvalid_r)
    `CHK("cfg_rdata", x, cfg_rdata_r)
  endtask
  // one external move, odd addresses write, waiting a bounded time
  task automatic xm(input logic [15:0] a, input logic f);
    int n;
    @(posedge clock) xm_req <= '{1'b1, a[0], a, a[7:0]};
    @(posedge clock) xm_req.valid <= 1'b0;
    #1;
    `CHK("fifo_req", f, mem_out_r.fifo_req)
    `CHK("external_data_ram_req", !f, mem_out_r.external_data_ram_req)
    `CHK("mem_addr", a[9:0], mem_out_r.addr)
    `CHK("mem_we", a[0], mem_out_r.we)
    `CHK("mem_wdata", a[7:0], mem_out_r.wdata)
    n = 0;
    while (xm_done_r !== 1'b1 && n < 20) begin
      `CHK("xm_wait", 1'b1, xm_wait_r)
      @(posedge clock);
      #1;
      n++;
    end
    `CHK("xm_done", 1'b1, xm_done_r)
  endtask
  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #50000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      dir(rows[i][22], 1'b0, rows[i][21:14], 8'h00);
      `CHK("sfr_sel", rows[i][13], dir_out_r.sfr_sel)
      `CHK("ram_sel", rows[i][12], dir_out_r.ram_sel)
      `CHK("reserved", rows[i][11], sfr_reserved_r)
      `CHK("bit_refused", 1'b0, bit_refused_r)
      `CHK("byte_addr", rows[i][10:3], dir_out_r.byte_addr)
      if (rows[i][22]) `CHK("bit_pos", rows[i][2:0], dir_out_r.bit_pos)
    end
    `CHK("cfg_reset", 8'h03, cfg_rdata_r)
    $display("direct decode test done");
    cfg(8'hFF, 8'h43);
    cfg(8'h3F, 8'h03);
    cfg(8'h40, 8'h43);
    xm(16'h0412, 1'b1);
    ack_delay <= 4'h4;
    xm(16'h07FF, 1'b1);
    xm(16'h0800, 1'b0);
    xm(16'h03FF, 1'b0);
    cfg(8'hBF, 8'h03);
    xm(16'h0412, 1'b0);
    xm(16'hFC12, 1'b0);
    $display("window test done");
    cfg(8'h40, 8'h43);
    @(posedge clock) sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    `CHK("cfg_in_reset", 8'h00, cfg_rdata_r)
    @(posedge clock) sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    `CHK("enable_reset", 1'b0, fifo_window_enable_r)
    `CHK("cfg_after_reset", 8'h03, cfg_rdata_r)
    $display("reset test done");
    finish_test();
  end
endmodule

//--- verification/sfrdw_fifo_model.sv
// fifo ram stand-in answering held requests with a level ack
// assumes request and answer share the core clock
module sfrdw_fifo_model (
  input wire logic clock, // core clock
  input wire logic sys_rst, // async reset, high
  input wire logic fifo_req, // held until acknowledged
  input wire logic [3:0] ack_delay, // cycles before the answer
  output logic fifo_ack // level, drops after the request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r; // cycles spent on this request
  // usb side taken as fast enough; only the stretch is modelled
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r <= 4'h0;
      fifo_ack <= 1'b0;
    end else if (!fifo_req) begin // released: answer goes
      wait_r <= 4'h0;
      fifo_ack <= 1'b0;
    end else if (wait_r == ack_delay) begin
      fifo_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

//--- verification/sfrdw_monitor.sv
// checker on the ports of the register decode block
// assumes one clock domain; bound into every sfrdw_top
module sfrdw_monitor (
  input wire logic clock, // clock
  input wire logic sys_rst, // reset
  input wire sfrdw_pkg::sfrdw_dir_req_t dir_req, // direct
  input wire sfrdw_pkg::sfrdw_xm_req_t xm_req, // move
  input wire logic fifo_ack, // ack
  input wire sfrdw_pkg::sfrdw_dir_route_t dir_out_r, // route
  input wire logic sfr_reserved_r, // reserved
  input wire logic bit_refused_r, // refused
  input wire logic [7:0] cfg_rdata_r, // cfg data
  input wire logic cfg_rvalid_r, // cfg read
  input wire logic fifo_window_enable_r, // window
  input wire sfrdw_pkg::sfrdw_mem_req_t mem_out_r, // memory
  input wire logic xm_wait_r, // stall
  input wire logic xm_done_r // done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // strobes taken this edge; a move counts only with the sequencer idle
  wire byte_go = dir_req.valid && !dir_req.bit_op;
  wire xm_go = xm_req.valid && !xm_wait_r;
  wire win = fifo_window_enable_r && xm_req.addr[15:10] == 6'h01;
  AST_SFR_SEL: assert property (
    byte_go && dir_req.addr[7] |=> dir_out_r.sfr_sel && !dir_out_r.ram_sel)
    else $error("upper direct byte not routed to registers");
  AST_BIT_MAP: assert property (
    dir_req.valid && dir_req.bit_op && dir_req.addr[7] |=> dir_out_r.sfr_sel
    && dir_out_r.byte_addr == {$past(dir_req.addr[7:3]), 3'h0}
    && dir_out_r.bit_pos == $past(dir_req.addr[2:0]))
    else $error("register bit access mapped wrongly");
  AST_NO_REFUSE: assert property (!bit_refused_r)
    else $error("legal bit access refused");
  AST_EN_WR: assert property (
    byte_go && dir_req.we && dir_req.addr == 8'h85
    |=> fifo_window_enable_r == $past(dir_req.wdata[6]))
    else $error("window enable not written");
  AST_CFG_RD: assert property (
    byte_go && !dir_req.we && dir_req.addr == 8'h85 |=> cfg_rvalid_r
    && cfg_rdata_r == {1'b0, $past(fifo_window_enable_r), 6'h03})
    else $error("config read value wrong");
  AST_RAM_MOVE: assert property (
    xm_go && !win |=> mem_out_r.external_data_ram_req && !mem_out_r.fifo_req
    && xm_done_r && mem_out_r.addr == $past(xm_req.addr[9:0]))
    else $error("ram move misrouted");
  AST_FIFO_MOVE: assert property (
    xm_go && win |=> mem_out_r.fifo_req && xm_wait_r && !mem_out_r.external_data_ram_req)
    else $error("window move misrouted");
  AST_ACK_DONE: assert property (
    mem_out_r.fifo_req && fifo_ack |=> !xm_wait_r && xm_done_r
    && !mem_out_r.fifo_req ##1 (!xm_done_r || $past(xm_req.valid)))
    else $error("stall not ended by ack");
endmodule

bind sfrdw_top sfrdw_monitor i_mon (.clock(clock), .sys_rst(sys_rst),
  .dir_req(dir_req), .xm_req(xm_req), .fifo_ack(fifo_ack),
  .dir_out_r(dir_out_r), .sfr_reserved_r(sfr_reserved_r),
  .bit_refused_r(bit_refused_r), .cfg_rdata_r(cfg_rdata_r),
  .cfg_rvalid_r(cfg_rvalid_r), .fifo_window_enable_r(fifo_window_enable_r),
  .mem_out_r(mem_out_r), .xm_wait_r(xm_wait_r), .xm_done_r(xm_done_r));
